// file: logic/lcd_cfg_pkg.sv
// constants for the lcd mode and configuration decoder
// assumes one core clock; settings arrive as plain synchronous ports
package lcd_cfg_pkg;
  localparam logic [1:0] DW_00 = 2'h0;
  localparam logic [1:0] DW_01 = 2'h1;
  localparam logic [1:0] DW_10 = 2'h2;
  localparam logic [1:0] DW_11 = 2'h3;
  localparam logic [1:0] PS_SOFT = 2'h0;
  localparam logic [1:0] PS_NORMAL = 2'h3;
  localparam logic [1:0] BPP_1 = 2'h0;
  localparam logic [1:0] BPP_2 = 2'h1;
  localparam logic [1:0] BPP_4 = 2'h2;
  localparam logic [1:0] BPP_8 = 2'h3;
  localparam logic [2:0] DIV_LAST_1BPP = 3'h3;
  localparam logic [2:0] DIV_LAST_2BPP = 3'h1;
  localparam logic [2:0] DIV_ZERO = 3'h0;
  localparam logic [2:0] DIV_ONE = 3'h1;
  localparam int ENTRY_W = 8;
  localparam logic [ENTRY_W-1:0] ENTRY_ONE = 8'h01;
  localparam logic [ENTRY_W-1:0] ENTRY_ZERO = 8'h00;

  typedef enum logic [3:0] {
    FMT_RESERVED = 4'b0000,
    FMT_MONO_S4 = 4'b0001,
    FMT_MONO_S8 = 4'b0010,
    FMT_MONO_D8 = 4'b0011,
    FMT_COL_S4 = 4'b0100,
    FMT_COL_S8F1 = 4'b0101,
    FMT_COL_S8F2 = 4'b0110,
    FMT_COL_D8 = 4'b0111,
    FMT_AM_9 = 4'b1000,
    FMT_AM_12 = 4'b1001
  } panel_fmt_t;

  typedef enum logic [1:0] {
    TBL_RED = 2'b00,
    TBL_GREEN = 2'b01,
    TBL_BLUE = 2'b10
  } lut_tbl_t;

  typedef enum logic [1:0] {
    PWR_SOFT = 2'b00,
    PWR_NORMAL = 2'b01,
    PWR_RESERVED = 2'b10
  } pwr_mode_t;
endpackage

// file: logic/lcd_mode_config_decode.sv
// lcd mode decode: panel format, memory clock ratio, power save, lut steps
// assumes settings are synchronous to i_core_clk and held while in use
// Function
// - passive mono single: width 00 gives 4-bit, 01 gives 8-bit
// - passive colour single: 00 4-bit, 01 8-bit format 1, 11 format 2
// - dual passive panels support only 8-bit, width code 01
// - memory clock is pixel clock over 8,4,2,1 by depth, or equal
// - power save field: 00 software power save, 11 normal
// - mono mode: lut accesses use green table, stepping entries
// - colour select 00 cycles red, green, blue; others fix one table
module lcd_mode_config_decode
  import lcd_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // panel settings
  input wire logic i_panel_type_select,
  input wire logic i_color_mode,
  input wire logic i_dual_panel,
  input wire logic [1:0] i_data_width,
  // clock settings
  input wire logic [1:0] i_bpp,
  input wire logic i_high_perf,
  input wire logic i_pixel_clock,
  // power save
  input wire logic [1:0] i_power_save,
  // lookup table access
  input wire logic [1:0] i_lut_select,
  input wire logic i_lut_load,
  input wire logic [ENTRY_W-1:0] i_lut_start,
  input wire logic i_lut_access,
  // decoded outputs
  output logic [3:0] o_panel_fmt,
  output logic o_memory_clock,
  output logic [1:0] o_power_mode,
  output logic [1:0] o_lut_table,
  output logic [ENTRY_W-1:0] o_lut_entry
);
  panel_fmt_t fmt_r, fmt_nxt;
  pwr_mode_t pwr_r, pwr_nxt;
  logic [2:0] div_cnt_r, div_cnt_nxt;
  logic [2:0] div_last;
  logic mclk_r, mclk_nxt;
  logic mclk_follow_r, mclk_follow_nxt;
  lut_tbl_t tbl_r, tbl_nxt;
  logic [ENTRY_W-1:0] entry_r, entry_nxt;

  // panel format decode
  always_comb
  begin
    fmt_nxt = FMT_RESERVED;
    if (i_panel_type_select)
    begin
      fmt_nxt = i_data_width[0] ? FMT_AM_12 : FMT_AM_9;
    end
    else if (i_dual_panel)
    begin
      if (i_data_width == DW_01)
      begin
        fmt_nxt = i_color_mode ? FMT_COL_D8 : FMT_MONO_D8;
      end
    end
    else if (!i_color_mode)
    begin
      case (i_data_width)
        DW_00: fmt_nxt = FMT_MONO_S4;
        DW_01: fmt_nxt = FMT_MONO_S8;
        default: fmt_nxt = FMT_RESERVED;
      endcase
    end
    else
    begin
      case (i_data_width)
        DW_00: fmt_nxt = FMT_COL_S4;
        DW_01: fmt_nxt = FMT_COL_S8F1;
        DW_11: fmt_nxt = FMT_COL_S8F2;
        default: fmt_nxt = FMT_RESERVED;
      endcase
    end
  end

  // power save decode; reserved codes flagged, not acted on
  always_comb
  begin
    case (i_power_save)
      PS_SOFT: pwr_nxt = PWR_SOFT;
      PS_NORMAL: pwr_nxt = PWR_NORMAL;
      default: pwr_nxt = PWR_RESERVED;
    endcase
  end

  // memory clock: toggle every ratio/2 pixel clocks, sampled as a level
  always_comb
  begin
    case (i_bpp)
      BPP_1: div_last = DIV_LAST_1BPP;
      BPP_2: div_last = DIV_LAST_2BPP;
      default: div_last = DIV_ZERO;
    endcase
    // edge detect lags a core cycle; pixel clock must stay below core/2
    mclk_follow_nxt = i_pixel_clock;
    div_cnt_nxt = div_cnt_r;
    mclk_nxt = mclk_r;
    if (i_high_perf || i_bpp == BPP_8)
    begin
      mclk_nxt = i_pixel_clock;
      div_cnt_nxt = DIV_ZERO;
    end
    else if (i_pixel_clock && !mclk_follow_r)
    begin
      if (div_cnt_r >= div_last)
      begin
        div_cnt_nxt = DIV_ZERO;
        mclk_nxt = ~mclk_r;
      end
      else
      begin
        div_cnt_nxt = div_cnt_r + DIV_ONE;
      end
    end
  end

  // lookup table pointer sequencing
  always_comb
  begin
    tbl_nxt = tbl_r;
    entry_nxt = entry_r;
    if (i_lut_load)
    begin
      entry_nxt = i_lut_start;
      if (!i_color_mode)
        tbl_nxt = TBL_GREEN;
      else
        case (i_lut_select)
          DW_00: tbl_nxt = TBL_RED;
          DW_01: tbl_nxt = TBL_RED;
          DW_10: tbl_nxt = TBL_GREEN;
          default: tbl_nxt = TBL_BLUE;
        endcase
    end
    else if (i_lut_access)
    begin
      if (!i_color_mode)
      begin
        tbl_nxt = TBL_GREEN;
        entry_nxt = entry_r + ENTRY_ONE;
      end
      else if (i_lut_select == DW_00)
      begin
        case (tbl_r)
          TBL_RED: tbl_nxt = TBL_GREEN;
          TBL_GREEN: tbl_nxt = TBL_BLUE;
          default:
          begin
            tbl_nxt = TBL_RED;
            entry_nxt = entry_r + ENTRY_ONE;
          end
        endcase
      end
      else
      begin
        entry_nxt = entry_r + ENTRY_ONE;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fmt_r <= FMT_RESERVED;
      pwr_r <= PWR_SOFT;
      div_cnt_r <= DIV_ZERO;
      mclk_r <= 1'b0;
      mclk_follow_r <= 1'b0;
      tbl_r <= TBL_GREEN;
      entry_r <= ENTRY_ZERO;
    end
    else
    begin
      fmt_r <= fmt_nxt;
      pwr_r <= pwr_nxt;
      div_cnt_r <= div_cnt_nxt;
      mclk_r <= mclk_nxt;
      mclk_follow_r <= mclk_follow_nxt;
      tbl_r <= tbl_nxt;
      entry_r <= entry_nxt;
    end
  end

  assign o_panel_fmt = fmt_r;
  assign o_memory_clock = mclk_r;
  assign o_power_mode = pwr_r;
  assign o_lut_table = tbl_r;
  assign o_lut_entry = entry_r;

  mono_single_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (!i_panel_type_select && !i_dual_panel && !i_color_mode
     && i_data_width == DW_01) |=> fmt_r == FMT_MONO_S8)
    else $error("mono single 8-bit not decoded");
  color_single_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (!i_panel_type_select && !i_dual_panel && i_color_mode
     && i_data_width == DW_11) |=> fmt_r == FMT_COL_S8F2)
    else $error("colour format 2 not decoded");
  dual_width_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (!i_panel_type_select && i_dual_panel && i_data_width != DW_01)
    |=> fmt_r == FMT_RESERVED)
    else $error("dual panel width not reserved");
  active_matrix_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    i_panel_type_select
    |=> fmt_r == ($past(i_data_width[0]) ? FMT_AM_12 : FMT_AM_9))
    else $error("active matrix width wrong");
  mclk_follow_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    i_high_perf |=> mclk_r == $past(i_pixel_clock))
    else $error("memory clock not pixel clock");
  power_mode_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    i_power_save == PS_NORMAL |=> pwr_r == PWR_NORMAL)
    else $error("normal power not decoded");
  mono_lut_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (!i_color_mode && i_lut_access && !i_lut_load)
    |=> tbl_r == TBL_GREEN && entry_r == $past(entry_r) + ENTRY_ONE)
    else $error("mono lut step wrong");
  auto_inc_a: assert property (@(posedge i_core_clk)
    disable iff (i_rst)
    (i_color_mode && i_lut_select == DW_00 && i_lut_access && !i_lut_load
     && tbl_r == TBL_RED) |=> tbl_r == TBL_GREEN && $stable(entry_r))
    else $error("auto increment order wrong");
endmodule

// file: sim/lcd_pixel_src.sv
// free running pixel clock source seen by the decoder
// assumes one core clock; the pixel clock derives from it
module lcd_pixel_src #(
  parameter int HALF = 4
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pixel clock level
  output logic o_pixel_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // moves on the falling edge, clear of the sampling edge
  always @(negedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= 0;
      o_pixel_clock <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      o_pixel_clock <= ~o_pixel_clock;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

// file: sim/test_lcd_mode_config_decode.sv
// self-checking bench for the lcd mode decoder
// assumes a pixel source model; inputs move on the falling edge
module test_lcd_mode_config_decode;
  timeunit 1ns;
  timeprecision 1ps;
  import lcd_cfg_pkg::*;
  logic clk = 0, rst = 1, tst = 0, col = 0, dual = 0, hp = 0;
  logic ld = 0, acc = 0, pix;
  logic [1:0] dw = 0, bpp = 0, ps = 0, sel = 0, pm, tb;
  logic [7:0] st = 0, ent;
  logic [3:0] fmt;
  logic mclk;
  int fails = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  lcd_pixel_src #(.HALF(4)) src (.i_core_clk(clk), .i_rst(rst),
    .o_pixel_clock(pix));
  lcd_mode_config_decode DUT (.i_core_clk(clk), .i_rst(rst),
    .i_panel_type_select(tst), .i_color_mode(col), .i_dual_panel(dual),
    .i_data_width(dw), .i_bpp(bpp), .i_high_perf(hp),
    .i_pixel_clock(pix), .i_power_save(ps), .i_lut_select(sel),
    .i_lut_load(ld), .i_lut_start(st), .i_lut_access(acc),
    .o_panel_fmt(fmt), .o_memory_clock(mclk), .o_power_mode(pm),
    .o_lut_table(tb), .o_lut_entry(ent));
  task automatic chk(input logic [7:0] got, exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [3:0] efmt(input logic [4:0] v);
    logic t, c, d;
    logic [1:0] w;
    {t, c, d, w} = v;
    if (t) return w[0] ? 4'h9 : 4'h8;
    if (d) return (w == 2'h1) ? (c ? 4'h7 : 4'h3) : 4'h0;
    if (w == 2'h0) return c ? 4'h4 : 4'h1;
    if (w == 2'h1) return c ? 4'h5 : 4'h2;
    return (c && w == 2'h3) ? 4'h6 : 4'h0;
  endfunction
  // three accesses after a load from entry 5, pulses back to back
  task automatic lut(input logic c, input logic [1:0] s);
    logic [1:0] et;
    logic au;
    au = c && s == 2'h0;
    col = c;
    sel = s;
    st = 8'h05;
    ld = 1;
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk);
      ld = 0;
      acc = k < 3;
      et = !c ? 2'h1 : au ? 2'(k % 3) : s - 2'h1;
      chk(tb, et, "table");
      chk(ent, 8'h05 + 8'(au ? k / 3 : k), "entry");
    end
    // idle cycle so the next call never reassigns the strobes at once
    @(negedge clk);
  endtask
  // edge detect lag is absorbed by a one-count tolerance
  task automatic mck(input logic h, input logic [1:0] b, input int r);
    int np, nm;
    logic pp, mp;
    hp = h;
    bpp = b;
    np = 0;
    nm = 0;
    // pixel level read on the rising edge, memory clock on the falling one
    repeat (40) @(posedge clk);
    pp = pix;
    @(negedge clk);
    mp = mclk;
    while (np < 64)
    begin
      @(posedge clk);
      np += int'(pix && !pp);
      pp = pix;
      @(negedge clk);
      nm += int'(mclk && !mp);
      mp = mclk;
    end
    chk(8'(nm >= 64 / r - 1 && nm <= 64 / r + 1), 8'h01, "mclk");
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 0;
    for (int i = 0; i < 32; i++)
    begin
      {tst, col, dual, dw} = 5'(i);
      @(negedge clk);
      chk(fmt, efmt(5'(i)), "fmt");
    end
    for (int i = 0; i < 4; i++)
    begin
      ps = 2'(i);
      @(negedge clk);
      chk(pm, i == 0 ? 2'h0 : i == 3 ? 2'h1 : 2'h2, "pwr");
    end
    lut(1'b0, 2'h3);
    for (int s = 0; s < 4; s++)
      lut(1'b1, 2'(s));
    mck(1'b0, 2'h0, 8);
    mck(1'b0, 2'h1, 4);
    mck(1'b0, 2'h2, 2);
    mck(1'b0, 2'h3, 1);
    mck(1'b1, 2'h0, 1);
    conclude();
  end
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
endmodule
